// ===== src/asblac_ctrl.sv
// Host controller for an asynchronous 16-bit SRAM with two byte lanes.
// Assumes the testbench resolves the shared data wire from dq_oe_n.
`timescale 1ns/1ps
`default_nettype none

module asblac_ctrl (
  // Clock and reset
  input  wire logic                          mclk,
  input  wire logic                          arst_n,
  // User request side
  input  wire logic                          req,
  input  wire logic                          req_write,
  input  wire logic [asblac_pkg::ADDR_W-1:0] req_addr,
  input  wire logic [asblac_pkg::DATA_W-1:0] req_wdata,
  input  wire logic [1:0]                    req_be,
  output logic                               ready,
  output logic [asblac_pkg::DATA_W-1:0]      rdata,
  output logic                               rvalid,
  // SRAM pins
  output logic [asblac_pkg::ADDR_W-1:0]      sram_addr,
  output logic                               chip_sel_n,
  output logic                               write_strobe_n,
  output logic                               out_drive_n,
  output logic                               upper_byte_lane_n,
  output logic                               lower_byte_lane_n,
  output logic [asblac_pkg::DATA_W-1:0]      dq_o,
  output logic                               dq_oe_n,
  input  wire logic [asblac_pkg::DATA_W-1:0] dq_i
);

  // All state but the reset synchroniser in one packed record; dq_s1 and dq_s2 are the two
  // synchroniser stages for read data coming off the clockless RAM
  typedef struct packed {
    asblac_pkg::asblac_state_e        state;
    logic [asblac_pkg::CNT_W-1:0]     cnt;
    logic                             ready;
    logic [asblac_pkg::DATA_W-1:0]    rdata;
    logic                             rvalid;
    logic [asblac_pkg::ADDR_W-1:0]    addr;
    logic                             cs_n;
    logic                             we_n;
    logic                             oe_n;
    logic                             ub_n;
    logic                             lb_n;
    logic [asblac_pkg::DATA_W-1:0]    dq_o;
    logic                             dq_oe_n;
    logic [asblac_pkg::DATA_W-1:0]    dq_s1;
    logic [asblac_pkg::DATA_W-1:0]    dq_s2;
  } asblac_st_s;

  logic [1:0] rst_sync_ff;
  logic       rst_n;
  asblac_st_s st_ff;
  asblac_st_s nxt_st;

  // Count helpers shared by every timed phase of the sequencer
  function automatic logic cnt_done(input logic [asblac_pkg::CNT_W-1:0] c);
    return c == '0;
  endfunction

  // Saturates at zero, so a stray extra cycle can never wrap the count
  function automatic logic [asblac_pkg::CNT_W-1:0] cnt_dec(
    input logic [asblac_pkg::CNT_W-1:0] c
  );
    return cnt_done(c) ? c : c - asblac_pkg::CNT_W'(1);
  endfunction

  // User enables are active high; the lane pins are active low
  function automatic logic [1:0] lanes_n(input logic [1:0] be);
    return ~be;
  endfunction

  // Reset release through two flops; assertion stays asynchronous
  // Only rst_n leaves this block; nothing else reads the first stage
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // Read: the pins stand while the access count runs down, the data is
  // registered as the count ends and the pins drop on that same edge;
  // a short turnaround count then lets the RAM float before ready.
  // Write: address, lanes and data first, strobe low for the pulse
  // count, strobe up, then one hold cycle with data still driven.
  // Trade-off: drive enable stays high on writes, so the plain pulse
  // width suffices and the RAM never drives into our data.
  // Next-state logic for the whole access sequencer
  always_comb begin
    nxt_st        = st_ff;
    // Read data crosses in from a clockless part: two flops first
    nxt_st.dq_s1  = dq_i;
    nxt_st.dq_s2  = st_ff.dq_s1;
    nxt_st.rvalid = 1'b0;
    unique case (st_ff.state)
      asblac_pkg::ASBLAC_IDLE: begin
        if (req) begin
          nxt_st.ready = 1'b0;
          // Address, select and lanes change together
          nxt_st.addr  = req_addr;
          nxt_st.cs_n  = 1'b0;
          {nxt_st.ub_n, nxt_st.lb_n} = lanes_n(req_be);
          nxt_st.we_n  = 1'b1;
          if (req_write) begin
            // Drive enable held high, so RAM never drives
            nxt_st.oe_n    = 1'b1;
            nxt_st.dq_o    = req_wdata;
            nxt_st.dq_oe_n = 1'b0;
            nxt_st.state   = asblac_pkg::ASBLAC_WR_SET;
          end else begin
            nxt_st.oe_n  = 1'b0;
            nxt_st.cnt   = asblac_pkg::RD_CNT_INIT;
            nxt_st.state = asblac_pkg::ASBLAC_RD_ACC;
          end
        end
      end
      asblac_pkg::ASBLAC_RD_ACC: begin
        // Wait out access time plus synchroniser latency
        if (cnt_done(st_ff.cnt)) begin
          nxt_st.rdata  = st_ff.dq_s2;
          nxt_st.rvalid = 1'b1;
          nxt_st.cs_n   = 1'b1;
          nxt_st.oe_n   = 1'b1;
          nxt_st.ub_n   = 1'b1;
          nxt_st.lb_n   = 1'b1;
          nxt_st.cnt    = asblac_pkg::OHZ_CNT_INIT;
          nxt_st.state  = asblac_pkg::ASBLAC_RD_END;
        end else begin
          nxt_st.cnt = cnt_dec(st_ff.cnt);
        end
      end
      asblac_pkg::ASBLAC_RD_END: begin
        // Bus turnaround: RAM must float before anyone may drive
        if (cnt_done(st_ff.cnt)) begin
          nxt_st.ready = 1'b1;
          nxt_st.state = asblac_pkg::ASBLAC_IDLE;
        end else begin
          nxt_st.cnt = cnt_dec(st_ff.cnt);
        end
      end
      asblac_pkg::ASBLAC_WR_SET: begin
        // Strobe falls last, opening the write window
        nxt_st.we_n  = 1'b0;
        nxt_st.cnt   = asblac_pkg::WP_CNT_INIT;
        nxt_st.state = asblac_pkg::ASBLAC_WR_PULSE;
      end
      asblac_pkg::ASBLAC_WR_PULSE: begin
        // Pulse covers both strobe width and data setup
        if (cnt_done(st_ff.cnt)) begin
          nxt_st.we_n  = 1'b1;
          nxt_st.state = asblac_pkg::ASBLAC_WR_HOLD;
        end else begin
          nxt_st.cnt = cnt_dec(st_ff.cnt);
        end
      end
      asblac_pkg::ASBLAC_WR_HOLD: begin
        // Address and data held one cycle past the strobe's rise
        nxt_st.cs_n    = 1'b1;
        nxt_st.ub_n    = 1'b1;
        nxt_st.lb_n    = 1'b1;
        nxt_st.dq_oe_n = 1'b1;
        nxt_st.ready   = 1'b1;
        nxt_st.state   = asblac_pkg::ASBLAC_IDLE;
      end
      default: begin
        // Unused state code: release the RAM and fall back to idle
        nxt_st.cs_n    = 1'b1;
        nxt_st.we_n    = 1'b1;
        nxt_st.oe_n    = 1'b1;
        nxt_st.ub_n    = 1'b1;
        nxt_st.lb_n    = 1'b1;
        nxt_st.dq_oe_n = 1'b1;
        nxt_st.ready   = 1'b1;
        nxt_st.state   = asblac_pkg::ASBLAC_IDLE;
      end
    endcase
  end

  // State register; pins idle deselected with all strobes high.
  // Runs on the synchronised reset, so every field leaves reset on the
  // same edge and no strobe can glitch low while the rest still reset.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '{state: asblac_pkg::ASBLAC_IDLE, cnt: '0, ready: 1'b1,
                 rdata: '0, rvalid: 1'b0, addr: '0, cs_n: 1'b1,
                 we_n: 1'b1, oe_n: 1'b1, ub_n: 1'b1, lb_n: 1'b1,
                 dq_o: '0, dq_oe_n: 1'b1, dq_s1: '0, dq_s2: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Every output is a field of the state register: no gate sits between
  // a flop and a pin, so all pins switch together one clock-to-out late
  assign ready             = st_ff.ready;
  assign rdata             = st_ff.rdata;
  assign rvalid            = st_ff.rvalid;
  assign sram_addr         = st_ff.addr;
  assign chip_sel_n        = st_ff.cs_n;
  assign write_strobe_n    = st_ff.we_n;
  assign out_drive_n       = st_ff.oe_n;
  assign upper_byte_lane_n = st_ff.ub_n;
  assign lower_byte_lane_n = st_ff.lb_n;
  assign dq_o              = st_ff.dq_o;
  assign dq_oe_n           = st_ff.dq_oe_n;

endmodule // asblac_ctrl

`default_nettype wire

// ===== src/asblac_pkg.sv
// Constants for the asynchronous SRAM host controller.
// Assumes a single 250 MHz clock; times are in ns and rounded here.
package asblac_pkg;
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_AA_NS       = 10; // Address access time
  localparam int T_WP_NS       = 7;  // Write strobe low time
  localparam int T_DW_NS       = 5;  // Data valid to end of write
  localparam int T_OHZ_NS      = 5;  // Output drive enable high to float
  localparam int T_WHZ_NS      = 5;  // Strobe low to float, unused: drive
                                     // enable kept high on writes
  localparam int SYNC_STAGES   = 2;
  localparam int ADDR_W        = 16;
  localparam int DATA_W        = 16;
  localparam int CNT_W         = 4;

  // Least times, rounded up to whole cycles
  localparam int AA_CYC  = (T_AA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WP_MIN  = (T_WP_NS > T_DW_NS) ? T_WP_NS : T_DW_NS;
  localparam int WP_CYC  = (WP_MIN + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OHZ_CYC = (T_OHZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_WAIT = AA_CYC + SYNC_STAGES;

  localparam logic [CNT_W-1:0] RD_CNT_INIT  = CNT_W'(RD_WAIT);
  localparam logic [CNT_W-1:0] WP_CNT_INIT  = CNT_W'(WP_CYC - 1);
  localparam logic [CNT_W-1:0] OHZ_CNT_INIT = CNT_W'(OHZ_CYC - 1);

  typedef enum logic [2:0] {
    ASBLAC_IDLE, ASBLAC_RD_ACC, ASBLAC_RD_END,
    ASBLAC_WR_SET, ASBLAC_WR_PULSE, ASBLAC_WR_HOLD
  } asblac_state_e;
endpackage

// ===== testbench/asblac_ctrl_tb.sv
// Self-checking bench for the SRAM host controller.
// Assumes the controller, RAM model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, v) begin checks++; if ((v) !== (e)) begin \
  miscompares++; $display("unexpected %s exp %h got %h", n, e, v); end end
module asblac_ctrl_tb;
  logic        mclk = 0, arst_n = 0, req = 0, req_write = 0;
  logic        ready, rvalid, chip_sel_n, write_strobe_n, out_drive_n;
  logic        upper_byte_lane_n, lower_byte_lane_n, dq_oe_n;
  logic [15:0] req_addr = 0, req_wdata = 0, rdata, sram_addr, dq_o, ram_dq;
  logic [1:0]  req_be = 0;
  int          checks = 0, miscompares = 0;
  // Shared data wire: the controller wins only while it drives
  wire  [15:0] dq_i = dq_oe_n ? ram_dq : dq_o;
  asblac_ctrl asblac_ctrl_i (.*);
  asblac_sram_model asblac_sram_model_i (.*);
  initial forever #2 mclk = ~mclk;
  // One access, held until the controller takes it
  task acc(input logic w, input logic [15:0] a, d, input logic [1:0] be);
    @(posedge mclk);
    req <= 1; req_write <= w; req_addr <= a; req_wdata <= d; req_be <= be;
    do @(posedge mclk); while (ready !== 1'b1);
    req <= 0;
  endtask
  // Read, then sample the data strobe at its fixed edge
  task rd(input logic [15:0] a, input logic [1:0] be, output logic [15:0] q);
    acc(0, a, 16'h0, be);
    // The data strobe is set on the sixth edge after the take
    repeat (7) @(posedge mclk);
    `CHK("rvalid", 1'b1, rvalid)
    q = rdata;
  endtask
  task t_reset;
    logic [6:0] pins;
    pins = {ready, chip_sel_n, write_strobe_n, out_drive_n,
            upper_byte_lane_n, lower_byte_lane_n, dq_oe_n};
    `CHK("idle pins", 7'h7f, pins)
  endtask
  task t_word;
    logic [15:0] q;
    acc(1, 16'h0010, 16'h1234, 2'h3);
    rd(16'h0010, 2'h3, q);
    `CHK("word", 16'h1234, q)
  endtask
  task t_lanes;
    logic [15:0] q;
    acc(1, 16'hffff, 16'ha5c3, 2'h3);
    acc(1, 16'hffff, 16'h7e11, 2'h2);
    acc(1, 16'hffff, 16'h2299, 2'h1);
    acc(1, 16'hffff, 16'h0000, 2'h0);
    rd(16'hffff, 2'h3, q);
    `CHK("lanes", 16'h7e99, q)
    rd(16'hffff, 2'h2, q);
    `CHK("upper", 8'h7e, q[15:8])
  endtask
  task end_of_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    arst_n <= 1;
    repeat (3) @(posedge mclk);
    t_reset;
    t_word;
    t_lanes;
    end_of_test;
  end
  // About 55 cycles of traffic; far more means a hang
  initial begin
    #8000;
    miscompares++;
    end_of_test;
  end
endmodule // asblac_ctrl_tb
bind asblac_ctrl asblac_properties asblac_properties_i (
  .mclk              (mclk),
  .arst_n            (arst_n),
  .req               (req),
  .req_write         (req_write),
  .ready             (ready),
  .rvalid            (rvalid),
  .req_addr          (req_addr),
  .sram_addr         (sram_addr),
  .req_be            (req_be),
  .chip_sel_n        (chip_sel_n),
  .write_strobe_n    (write_strobe_n),
  .out_drive_n       (out_drive_n),
  .dq_oe_n           (dq_oe_n),
  .upper_byte_lane_n (upper_byte_lane_n),
  .lower_byte_lane_n (lower_byte_lane_n)
);
`default_nettype wire

// ===== testbench/asblac_properties.sv
// Pin timing checker for the SRAM host controller.
// Assumes it is bound to asblac_ctrl and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module asblac_properties (
  // Clock, reset, user side and SRAM address
  input wire logic        mclk,
  input wire logic        arst_n,
  input wire logic        req,
  input wire logic        req_write,
  input wire logic        ready,
  input wire logic        rvalid,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] sram_addr,
  input wire logic [1:0]  req_be,
  // SRAM controls
  input wire logic        chip_sel_n,
  input wire logic        write_strobe_n,
  input wire logic        out_drive_n,
  input wire logic        dq_oe_n,
  input wire logic        upper_byte_lane_n,
  input wire logic        lower_byte_lane_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // Request accepted at this edge
  wire take = req && ready;
  a_rd_strobe: assert property (!out_drive_n |-> write_strobe_n)
    else $error("strobe low while RAM drives");
  a_no_fight: assert property (!dq_oe_n |-> out_drive_n)
    else $error("both sides drive data");
  a_wr_overlap: assert property (
    !write_strobe_n |-> !chip_sel_n && !dq_oe_n) else $error("bad overlap");
  a_sel_first: assert property (
    $fell(write_strobe_n) |-> $past(chip_sel_n) == 1'b0)
    else $error("select late");
  a_pulse_len: assert property ($fell(write_strobe_n) |=>
    !write_strobe_n ##1 write_strobe_n && !dq_oe_n) else $error("pulse");
  a_addr_lanes: assert property (take |=> sram_addr == $past(req_addr) &&
    {upper_byte_lane_n, lower_byte_lane_n} == ~$past(req_be))
    else $error("address or lanes wrong");
  // Read data is registered on the edge after the access count ends
  a_rd_timing: assert property (take && !req_write |->
    ##7 rvalid ##1 !rvalid ##1 ready) else $error("read timing");
  a_wr_timing: assert property (take && req_write |->
    ##1 !ready [*4] ##1 ready) else $error("write timing");
  a_drive_turn: assert property ($fell(dq_oe_n) |->
    $past(out_drive_n)) else $error("drive while RAM enabled");
  // Main traffic seen
  c_read: cover property (take && !req_write);
  c_write: cover property (take && req_write);
  c_rvalid: cover property (rvalid);
  c_part_lane: cover property (take && req_write && ^req_be);
endmodule // asblac_properties
`default_nettype wire

// ===== testbench/asblac_sram_model.sv
// Behavioural 16-bit asynchronous RAM with two byte lanes.
// Assumes the bench resolves the shared data wire into dq_i.
`timescale 1ns/1ps
`default_nettype none
module asblac_sram_model (
  // Pins from the host
  input wire logic [15:0] sram_addr,
  input wire logic [15:0] dq_i,
  input wire logic        chip_sel_n,
  input wire logic        write_strobe_n,
  input wire logic        out_drive_n,
  input wire logic        upper_byte_lane_n,
  input wire logic        lower_byte_lane_n,
  // What the RAM puts on the wire
  output logic [15:0]     ram_dq
);
  logic [15:0] mem [0:65535];
  // No clock: pin levels alone decide
  wire wr = !chip_sel_n && !write_strobe_n;
  wire rd = !chip_sel_n && !out_drive_n && write_strobe_n;
  // Lanes latch as the overlap closes
  always @(negedge wr) begin
    if (!upper_byte_lane_n) mem[sram_addr][15:8] = dq_i[15:8];
    if (!lower_byte_lane_n) mem[sram_addr][7:0] = dq_i[7:0];
  end
  // Floating lanes show changed data, never a stale copy
  always @* begin
    ram_dq = ~mem[sram_addr];
    if (rd && !upper_byte_lane_n) ram_dq[15:8] = mem[sram_addr][15:8];
    if (rd && !lower_byte_lane_n) ram_dq[7:0] = mem[sram_addr][7:0];
  end
endmodule // asblac_sram_model
`default_nettype wire
